/* sscb_pkg.sv */
package sscb_pkg;
	localparam int ADDR_W = 18;
	localparam int BYTES = 4;
	localparam int BYTE_W = 9;
	localparam int DATA_W = 36;
	localparam int MEM_DEPTH = 64;
	localparam int MEM_AW = 6;
	localparam int BURST_W = 2;
	localparam int SLEEP_ENTRY_CYCLES = 2;
	localparam int CLK_PERIOD_NS = 40;
	localparam int SLEEP_RECOVERY_NS = 100;
	localparam int SLEEP_RECOVERY_CYCLES = (SLEEP_RECOVERY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int PARITY_BIT = 8;
	typedef enum logic [1:0] {
		SSCB_OP_DESEL,
		SSCB_OP_READ,
		SSCB_OP_WRITE
	} sscb_op_t;
endpackage

/* sscb_burst_addr.sv */
`timescale 1ns/100ps
// two-bit burst counter and low-address generator
module sscb_burst_addr (
	input wire logic ref_clk_i,
	input wire logic sys_rst_i,
	input wire logic load_i,
	input wire logic step_i,
	input wire logic linear_order_n_i,
	input wire logic [sscb_pkg::BURST_W-1:0] start_i,
	output logic [sscb_pkg::BURST_W-1:0] low_addr_o
);
	logic [sscb_pkg::BURST_W-1:0] start_q;
	logic [sscb_pkg::BURST_W-1:0] count_q;
	logic [sscb_pkg::BURST_W-1:0] count_nx;

	// continue cycles use the next count, so the first continue is start plus one in linear order and start xor one in interleaved order
	assign count_nx = count_q + 2'h1;

	always_ff @(posedge ref_clk_i or posedge sys_rst_i)
	begin
		if (sys_rst_i)
		begin
			start_q <= '0;
			count_q <= '0;
		end
		else if (load_i)
		begin
			start_q <= start_i;
			count_q <= '0;
		end
		else if (step_i)
		begin
			count_q <= count_nx; // RULE_11
		end
	end

	always_comb
	begin
		if (linear_order_n_i)
			low_addr_o = start_q ^ count_nx; // RULE_13
		else
			low_addr_o = start_q + count_nx; // RULE_12
	end
endmodule

/* sscb_sram.sv */
`timescale 1ns/100ps
// Operation
// RULE_01: low advance on selected edge loads address
// RULE_02: high advance steps burst counter address
// RULE_03: continue cycles repeat burst operation type
// RULE_04: deselect-continue only after a deselect cycle
// RULE_05: write with no byte enables is no-op
// RULE_06: read with output enable high is dummy
// RULE_07: drivers off during writes automatically
// RULE_08: clock enable high freezes all state; the pin synchronisers and the sleep entry and recovery logic keep running
// RULE_09: controller inserts waits via clock enable
// RULE_10: outputs high impedance during power-up
// RULE_11: two-bit counter wraps on fifth clock
// RULE_12: linear order counts modulo four
// RULE_13: interleaved order xors start with count
// RULE_14: open pins default via pulls
// RULE_15: ninth-bit enable low activates parity pins
// RULE_16: sleep entered two cycles after request
// RULE_17: asleep acts deselected, outputs high impedance
// RULE_18: controller drains operations before sleep
// RULE_19: only deselect or read during recovery
// RULE_20: selected only when all three enables active
// RULE_21: pipelined read data one edge later
// RULE_22: pipelined write data at third edge
// RULE_23: flow-through pipelines one cycle shorter
// RULE_24: each byte enable gates its lane
// RULE_25: output enable high forces high impedance
module sscb_sram (
	input wire logic ref_clk_i,
	input wire logic sys_rst_i,
	input wire logic clk_enable_n_i,
	input wire logic advance_or_load_i,
	input wire logic write_n_i,
	input wire logic [sscb_pkg::BYTES-1:0] byte_write_n_i,
	input wire logic select_a_n_i,
	input wire logic select_b_i,
	input wire logic select_c_n_i,
	input wire logic out_enable_n_i,
	input wire logic sleep_request_i,
	input wire logic sleep_request_open_i,
	input wire logic linear_order_n_i,
	input wire logic flowthrough_n_i,
	input wire logic flowthrough_n_open_i,
	input wire logic ninth_bit_enable_n_i,
	input wire logic ninth_bit_enable_n_open_i,
	input wire logic drive_select_i,
	input wire logic drive_select_open_i,
	input wire logic [sscb_pkg::ADDR_W-1:0] addr_i,
	input wire logic [sscb_pkg::DATA_W-1:0] data_i,
	output logic [sscb_pkg::DATA_W-1:0] data_o,
	output logic data_oe_o,
	output logic high_drive_o,
	output logic asleep_o
);
	// synchronised pins
	logic [5:0] pin_s1_q;
	logic [5:0] pin_s2_q;
	logic sleep_s;
	logic oe_n_s;
	logic order_s;
	logic flow_n_s;
	logic ninth_n_s;
	logic drv_s;
	// effective straps with pulls
	logic flow_n_eff;
	logic ninth_n_eff;
	logic sleep_eff;
	logic drv_eff;

	assign flow_n_eff = flowthrough_n_open_i ? 1'b1 : flowthrough_n_i; // RULE_14
	assign drv_eff = drive_select_open_i ? 1'b1 : drive_select_i; // RULE_14
	assign ninth_n_eff = ninth_bit_enable_n_open_i ? 1'b0 : ninth_bit_enable_n_i; // RULE_14
	assign sleep_eff = sleep_request_open_i ? 1'b0 : sleep_request_i; // RULE_14

	always_ff @(posedge ref_clk_i or posedge sys_rst_i)
	begin
		if (sys_rst_i)
		begin
			pin_s1_q <= '0;
			pin_s2_q <= '0;
		end
		else
		begin
			pin_s1_q <= {drv_eff, ninth_n_eff, flow_n_eff, linear_order_n_i, out_enable_n_i, sleep_eff};
			pin_s2_q <= pin_s1_q;
		end
	end
	assign {drv_s, ninth_n_s, flow_n_s, order_s, oe_n_s, sleep_s} = pin_s2_q;
	assign high_drive_o = ~drv_s;

	// sleep entry and recovery
	logic [1:0] sleep_cnt_q;
	logic asleep_q;
	logic [3:0] recov_q;
	logic active;

	always_ff @(posedge ref_clk_i or posedge sys_rst_i)
	begin
		if (sys_rst_i)
		begin
			sleep_cnt_q <= '0;
			asleep_q <= 1'b0;
			recov_q <= '0;
		end
		else if (sleep_s)
		begin
			recov_q <= '0;
			if (sleep_cnt_q == 2'(sscb_pkg::SLEEP_ENTRY_CYCLES - 1))
				asleep_q <= 1'b1; // RULE_16
			else
				sleep_cnt_q <= sleep_cnt_q + 2'h1;
		end
		else
		begin
			sleep_cnt_q <= '0;
			if (asleep_q)
			begin
				asleep_q <= 1'b0;
				recov_q <= 4'(sscb_pkg::SLEEP_RECOVERY_CYCLES);
			end
			else if (recov_q != 4'h0)
				recov_q <= recov_q - 4'h1;
		end
	end
	assign asleep_o = asleep_q;
	assign active = ~clk_enable_n_i & ~asleep_q; // RULE_08 RULE_17

	// command decode
	logic selected;
	logic any_byte;
	sscb_pkg::sscb_op_t op_q;
	sscb_pkg::sscb_op_t cmd_op;
	logic [sscb_pkg::ADDR_W-1:0] base_q;
	logic [sscb_pkg::BURST_W-1:0] low_addr;
	logic load;
	logic step;

	assign selected = ~select_a_n_i & select_b_i & ~select_c_n_i; // RULE_20
	assign any_byte = ~&byte_write_n_i;
	assign load = active & ~advance_or_load_i; // RULE_01
	assign step = active & advance_or_load_i & (op_q != sscb_pkg::SSCB_OP_DESEL); // RULE_02

	always_comb
	begin
		if (~advance_or_load_i)
		begin
			if (~selected)
				cmd_op = sscb_pkg::SSCB_OP_DESEL;
			else if (write_n_i)
				cmd_op = sscb_pkg::SSCB_OP_READ;
			else
				cmd_op = sscb_pkg::SSCB_OP_WRITE;
		end
		else
			cmd_op = op_q; // RULE_03 RULE_04
	end

	always_ff @(posedge ref_clk_i or posedge sys_rst_i)
	begin
		if (sys_rst_i)
		begin
			op_q <= sscb_pkg::SSCB_OP_DESEL;
			base_q <= '0;
		end
		else if (load)
		begin
			op_q <= cmd_op; // RULE_01
			base_q <= addr_i;
		end
	end

	sscb_burst_addr u_burst (
		.ref_clk_i(ref_clk_i),
		.sys_rst_i(sys_rst_i),
		.load_i(load),
		.step_i(step),
		.linear_order_n_i(order_s),
		.start_i(addr_i[sscb_pkg::BURST_W-1:0]),
		.low_addr_o(low_addr)
	);

	// current access address: external on load, counter on continue
	logic [sscb_pkg::MEM_AW-1:0] acc_addr;
	always_comb
	begin
		if (~advance_or_load_i)
			acc_addr = addr_i[sscb_pkg::MEM_AW-1:0];
		else
			acc_addr = {base_q[sscb_pkg::MEM_AW-1:sscb_pkg::BURST_W], low_addr};
	end

	// write pipeline: stage 1 to 2 (pipelined), data on second or third edge
	logic wr1_q;
	logic wr2_q;
	logic [sscb_pkg::BYTES-1:0] be1_q;
	logic [sscb_pkg::BYTES-1:0] be2_q;
	logic [sscb_pkg::MEM_AW-1:0] wa1_q;
	logic [sscb_pkg::MEM_AW-1:0] wa2_q;
	logic is_wr;
	logic wr_now;
	logic [sscb_pkg::BYTES-1:0] wr_be;
	logic [sscb_pkg::MEM_AW-1:0] wr_addr;

	assign is_wr = active & (cmd_op == sscb_pkg::SSCB_OP_WRITE) & (~advance_or_load_i | step);

	always_ff @(posedge ref_clk_i or posedge sys_rst_i)
	begin
		if (sys_rst_i)
		begin
			wr1_q <= 1'b0;
			wr2_q <= 1'b0;
			be1_q <= '0;
			be2_q <= '0;
			wa1_q <= '0;
			wa2_q <= '0;
		end
		else if (active)
		begin
			// writes are refused until sleep recovery has run out
			wr1_q <= is_wr & any_byte & (recov_q == 4'h0); // RULE_05 RULE_19
			be1_q <= ~byte_write_n_i;
			wa1_q <= acc_addr;
			wr2_q <= wr1_q;
			be2_q <= be1_q;
			wa2_q <= wa1_q;
		end
	end

	assign wr_now = active & (flow_n_s ? wr2_q : wr1_q); // RULE_22 RULE_23
	assign wr_be = flow_n_s ? be2_q : be1_q;
	assign wr_addr = flow_n_s ? wa2_q : wa1_q;

	// storage: one flop array per lane, so each lane has a single writer
	logic [sscb_pkg::MEM_AW-1:0] ra1_q;
	logic [sscb_pkg::DATA_W-1:0] rd_word;
	genvar gb;
	generate
		for (gb = 0; gb < sscb_pkg::BYTES; gb++)
		begin : g_lane
			logic [sscb_pkg::BYTE_W-1:0] lane_q [sscb_pkg::MEM_DEPTH];
			always_ff @(posedge ref_clk_i)
			begin
				if (wr_now & wr_be[gb]) // RULE_24
				begin
					lane_q[wr_addr] <= {
						ninth_n_s ? 1'b0 : data_i[gb*sscb_pkg::BYTE_W + sscb_pkg::PARITY_BIT], // RULE_15
						data_i[gb*sscb_pkg::BYTE_W +: sscb_pkg::PARITY_BIT]};
				end
			end
			assign rd_word[gb*sscb_pkg::BYTE_W +: sscb_pkg::BYTE_W] = lane_q[ra1_q];
		end
	endgenerate

	// read pipeline
	logic rd1_q;
	logic rd2_q;
	logic [sscb_pkg::DATA_W-1:0] dout_q;
	logic is_rd;
	logic drive;
	logic [sscb_pkg::DATA_W-1:0] par_mask;

	assign is_rd = active & (cmd_op == sscb_pkg::SSCB_OP_READ) & (~advance_or_load_i | step);

	always_ff @(posedge ref_clk_i or posedge sys_rst_i)
	begin
		if (sys_rst_i)
		begin
			rd1_q <= 1'b0;
			rd2_q <= 1'b0;
			ra1_q <= '0;
			dout_q <= '0;
		end
		else if (asleep_q)
		begin
			rd1_q <= 1'b0; // RULE_17
			rd2_q <= 1'b0;
		end
		else if (active)
		begin
			rd1_q <= is_rd & ~oe_n_s; // RULE_06
			ra1_q <= acc_addr;
			rd2_q <= rd1_q;
			dout_q <= flow_n_s ? (rd_word & par_mask) : dout_q; // RULE_21
		end
	end

	generate
		for (gb = 0; gb < sscb_pkg::BYTES; gb++)
		begin : g_par
			assign par_mask[gb*sscb_pkg::BYTE_W +: sscb_pkg::BYTE_W] =
				{~ninth_n_s, {sscb_pkg::PARITY_BIT{1'b1}}}; // RULE_15
		end
	endgenerate

	// drive: stall holds pipeline, writes and sleep force off
	assign drive = ~sys_rst_i & ~asleep_q & ~oe_n_s & ~wr_now
		& (flow_n_s ? rd2_q : rd1_q); // RULE_07 RULE_10 RULE_25
	assign data_oe_o = drive;
	assign data_o = flow_n_s ? dout_q : (rd_word & par_mask); // RULE_23

	a_sleep_entry: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i) // RULE_16
		sleep_s [*2] |=> asleep_q)
		else $error("sleep not entered after two cycles");
	a_asleep_quiet: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i) // RULE_17
		asleep_q |-> ~data_oe_o)
		else $error("driving while asleep");
	a_write_off: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i) // RULE_07
		wr_now |-> ~data_oe_o)
		else $error("driving during write");
	a_oe_force: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i) // RULE_25
		oe_n_s |-> ~data_oe_o)
		else $error("driving with output enable high");
	a_stall_hold: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i) // RULE_08
		clk_enable_n_i |=> ($stable(op_q) && $stable(base_q) && $stable(rd1_q)))
		else $error("state moved on stalled edge");
	a_abort_nop: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i) // RULE_05
		(active & ~advance_or_load_i & selected & ~write_n_i & ~any_byte) |=> ~wr1_q)
		else $error("write abort performed a write");
	a_pipe_read: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i) // RULE_21
		(active & flow_n_s & $stable(flow_n_s) & is_rd & ~oe_n_s) ##1 (active & ~oe_n_s)
		|=> rd2_q)
		else $error("pipelined read data not staged");
	a_load_op: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i) // RULE_20
		(load & ~selected) |=> (op_q == sscb_pkg::SSCB_OP_DESEL))
		else $error("load with inactive enable not deselected");
	a_recov_nowr: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i) // RULE_19
		(active && recov_q != 4'h0) |=> ~wr1_q)
		else $error("write accepted during sleep recovery");
endmodule

/* sscb_ctrl_model.sv */
`timescale 1ns/100ps
// controller side: write data delayed to match the device's late-write pipeline
module sscb_ctrl_model (
	input wire logic ref_clk_i,
	input wire logic cke_n_i,
	input wire logic flow_i,
	input wire logic wr_i,
	input wire logic [35:0] wd_i,
	output logic [35:0] data_o
);
	logic [35:0] s1_q = '0;
	logic [35:0] s2_q = '0;
	always_ff @(posedge ref_clk_i)
	begin
		if (!cke_n_i)
		begin
			s1_q <= wr_i ? wd_i : ~s1_q;
			s2_q <= s1_q;
		end
	end
	// idle bus shows the inverse of the word it showed one enabled edge before
	assign data_o = flow_i ? s1_q : s2_q;
endmodule

/* sscb_sram_test.sv */
`timescale 1ns/100ps
module sscb_sram_test;
	localparam logic [35:0] MASK = 36'h7_fbfd_feff;
	logic clk = 0, rst = 1, cke_n = 0, advance = 0, wn = 1, sa_n = 1, sb = 0, sc_n = 1;
	logic oe_n = 0, slp = 0, slp_op = 0, order_n = 0, ftn = 1, pen = 0, drv = 1, drv_op = 0;
	logic flow_open = 0, ninth_open = 0;
	logic mwr = 0;
	logic [3:0] bw = 4'hf;
	logic [17:0] addr = '0;
	logic [35:0] mwd = '0, din, dout;
	logic doe, hdrv, asleep;
	logic [2:0] ds [3] = '{3'h6, 3'h0, 3'h3};
	bit flow, par_off, oe_off;
	bit ev [0:1023];
	bit eo [0:1023];
	logic [35:0] ed [0:1023];
	logic [35:0] rm [0:63];
	int en_seen, n_fail, compares;
	initial forever #20 clk = ~clk;
	sscb_sram dut (.ref_clk_i(clk), .sys_rst_i(rst), .clk_enable_n_i(cke_n),
		.advance_or_load_i(advance), .write_n_i(wn), .byte_write_n_i(bw), .select_a_n_i(sa_n),
		.select_b_i(sb), .select_c_n_i(sc_n), .out_enable_n_i(oe_n), .sleep_request_i(slp),
		.sleep_request_open_i(slp_op), .linear_order_n_i(order_n), .flowthrough_n_i(ftn),
		.flowthrough_n_open_i(flow_open), .ninth_bit_enable_n_i(pen),
		.ninth_bit_enable_n_open_i(ninth_open),
		.drive_select_i(drv), .drive_select_open_i(drv_op), .addr_i(addr), .data_i(din),
		.data_o(dout), .data_oe_o(doe), .high_drive_o(hdrv), .asleep_o(asleep));
	sscb_ctrl_model ctl (.ref_clk_i(clk), .cke_n_i(cke_n), .flow_i(flow), .wr_i(mwr),
		.wd_i(mwd), .data_o(din));
	task automatic conclude();
		$display("fails %0d compares %0d", n_fail, compares);
		if (n_fail == 0 && compares > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask
	task automatic chk1(input logic g, input logic e);
		compares++;
		if (g !== e)
		begin
			n_fail++;
			$display("FAIL %0t flag %b exp %b", $time, g, e);
		end
	endtask
	task automatic chkd(input logic [35:0] g, input logic [35:0] e);
		compares++;
		if (g !== e)
		begin
			n_fail++;
			$display("FAIL %0t data %h exp %h", $time, g, e);
		end
	endtask
	task automatic tdone(input string s);
		$display("test %s done", s);
	endtask
	// one command per edge; expectation filed by enabled-edge count
	task automatic issue(input logic ld, w_n, input logic [3:0] b_n, input logic [2:0] en,
		input logic [17:0] a, input logic [35:0] wd, input logic [5:0] ea, input int op);
		int k;
		@(posedge clk);
		k = en_seen + !cke_n + (flow ? 1 : 2);
		advance <= !ld;
		wn <= w_n;
		bw <= b_n;
		{sa_n, sb, sc_n} <= en;
		addr <= a;
		mwr <= !w_n || op == 2;
		mwd <= wd;
		cke_n <= '0;
		ev[k] = '1;
		eo[k] = op == 1 && !oe_off;
		ed[k] = par_off ? rm[ea] & MASK : rm[ea];
		for (int j = 0; j < 4; j++)
			if (op == 2 && !b_n[j])
				rm[ea][9*j+:9] = wd[9*j+:9];
	endtask
	task automatic burst(input bit wr, input logic [17:0] a, input int n, input logic [35:0] b);
		logic [1:0] lo;
		for (int i = 0; i < n; i++)
		begin
			lo = order_n ? a[1:0] ^ i[1:0] : a[1:0] + i[1:0];
			if (i == 0)
				issue('1, !wr, '0, 3'h2, a, b, a[5:0], wr ? 2 : 1);
			else
				issue('0, wr, '0, 3'h5, ~a, b ^ 36'(i), {a[5:2], lo}, wr ? 2 : 1);
		end
	endtask
	task automatic desel(input int n);
		for (int i = 0; i < n; i++)
			issue(i == 0, '1, 4'hf, i == 0 ? 3'h6 : 3'h5, '0, '0, '0, 0);
	endtask
	task automatic stall(input int n);
		repeat (n) @(posedge clk) cke_n <= '1;
	endtask
	always @(posedge clk or posedge rst)
		if (rst)
			en_seen <= 0;
		else if (!cke_n)
			en_seen <= en_seen + 1;
	always @(negedge clk)
		if (!rst && ev[en_seen])
		begin
			chk1(doe, eo[en_seen]);
			if (eo[en_seen])
				chkd(dout, ed[en_seen]);
		end
	initial
	begin
		repeat (2) @(posedge clk);
		chk1(doe, '0);
		rst <= '0;
		desel(4);
		burst(1, 18'h0_0001, 4, 36'h1_2345_6789);
		desel(3);
		burst(0, 18'h0_0001, 5, '0);
		burst(0, 18'h0_0002, 2, '0);
		stall(3);
		desel(3);
		tdone("linear");
		order_n <= '1;
		desel(3);
		burst(1, 18'h0_000a, 4, 36'h5_5aa5_0ff0);
		desel(3);
		burst(0, 18'h0_000a, 5, '0);
		desel(3);
		tdone("interleaved");
		issue('1, '0, 4'h0, 3'h2, 18'h0_0014, 36'h3_3333_3333, 6'h14, 2);
		issue('1, '0, 4'ha, 3'h2, 18'h0_0014, 36'hc_cccc_cccc, 6'h14, 2);
		issue('1, '0, 4'hf, 3'h2, 18'h0_0014, 36'h0_0000_0000, 6'h14, 0);
		for (int i = 0; i < 3; i++)
			issue('1, '0, 4'h0, ds[i], 18'h0_0014, 36'h0_0000_0000, 6'h14, 0);
		desel(3);
		issue('1, '1, 4'hf, 3'h2, 18'h0_0014, '0, 6'h14, 1);
		desel(3);
		oe_n <= '1;
		oe_off = 1;
		desel(3);
		issue('1, '1, 4'hf, 3'h2, 18'h0_0014, '0, 6'h14, 1);
		oe_n <= '0;
		desel(3);
		oe_off = 0;
		tdone("lanes");
		ftn <= '0;
		pen <= '1;
		flow = 1;
		par_off = 1;
		desel(4);
		issue('1, '0, 4'h0, 3'h2, 18'h0_001e, 36'hf_ffff_ffff, 6'h1e, 2);
		desel(2);
		issue('1, '1, 4'hf, 3'h2, 18'h0_001e, '0, 6'h1e, 1);
		issue('1, '1, 4'hf, 3'h2, 18'h0_0014, '0, 6'h14, 1);
		desel(3);
		tdone("flow");
		drv <= '0;
		slp <= '1;
		slp_op <= '1;
		desel(4);
		@(negedge clk);
		chk1(hdrv, '1);
		chk1(asleep, '0);
		@(posedge clk);
		drv_op <= '1;
		slp_op <= '0;
		desel(6);
		@(negedge clk);
		chk1(hdrv, '0);
		chk1(asleep, '1);
		issue('1, '0, 4'h0, 3'h2, 18'h0_0014, 36'h0_0000_0000, 6'h14, 0);
		slp <= '0;
		desel(8);
		issue('1, '1, 4'hf, 3'h2, 18'h0_0014, '0, 6'h14, 1);
		desel(3);
		@(negedge clk);
		chk1(asleep, '0);
		tdone("sleep");
		@(posedge clk);
		flow_open <= '1;
		ninth_open <= '1;
		flow = 0;
		par_off = 0;
		desel(3);
		issue('1, '1, 4'hf, 3'h2, 18'h0_0014, '0, 6'h14, 1);
		desel(3);
		tdone("pulls");
		conclude();
	end
	initial
	begin
		#100000;
		n_fail++;
		conclude();
	end
endmodule
